// ===== hdl/ftl_pkg.sv
/*
 * constants, types and helpers shared by the fan speed supervision block.
 * assumes a 100 MHz system clock; the 90 kHz measurement rate is an enable.
 */
package ftl_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned MEAS_CLK_HZ  = 90_000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / MEAS_CLK_HZ;
  localparam longint      GUARD_MIN_NS = 88_880;
  localparam longint      NS_PER_S     = 1_000_000_000;
  localparam int unsigned GUARD_MIN_TICKS =
    int'((GUARD_MIN_NS * MEAS_CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [5:0]  GUARD_MAX_TICKS = 6'h3F;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_READ_BASE  = 8'h28;
  localparam logic [7:0] ADDR_READ_LAST  = 8'h2F;
  localparam logic [7:0] ADDR_STATUS     = 8'h42;
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h54;
  localparam logic [7:0] ADDR_LIMIT_LAST = 8'h5B;
  localparam logic [7:0] ADDR_CONFIG     = 8'h7F;
  localparam logic [7:0] ADDR_ENABLE     = 8'h80;
  localparam logic [7:0] ADDR_LINK       = 8'h81;
  localparam logic [7:0] ADDR_OPT_BASE   = 8'h90;
  localparam logic [7:0] ADDR_OPT_LAST   = 8'h93;

  // ==========================================================================
  // field positions and reset values
  localparam int unsigned STAT_TACH_LSB   = 2;
  localparam int unsigned ENABLE_GROUP    = 0;
  localparam int unsigned CONFIG_SPINCUT  = 4;
  localparam logic [7:0]  RST_ENABLE      = 8'h3C;
  localparam logic [7:0]  RST_LINK        = 8'hA4;
  localparam logic [7:0]  RST_CONFIG      = 8'h00;
  localparam logic [7:0]  RST_OPT         = 8'h00;
  localparam logic [15:0] RST_LIMIT       = 16'hFFFF;
  localparam logic [15:0] READ_STALL      = 16'hFFFF;
  localparam logic [15:0] READ_SLOW       = 16'hFFFE;
  localparam logic [15:0] LIMIT_OFF       = 16'hFFFF;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_GUARD = 3'b001,
    ST_ARM   = 3'b010,
    ST_COUNT = 3'b011,
    ST_HOLD  = 3'b100
  } ftl_state_t;

  typedef struct packed {
    logic [1:0] spare;
    logic       sync_mode;
    logic [1:0] guard_sel;
    logic [1:0] edge_sel;
    logic       slow_sel;
  } ftl_opt_t;

  typedef struct packed {
    logic        done;
    logic [15:0] value;
  } ftl_result_t;

  // ==========================================================================
  // helpers
  function automatic logic [3:0] edges_needed(input logic [1:0] sel);
    case (sel)
      2'b00:   edges_needed = 4'h2;
      2'b01:   edges_needed = 4'h3;
      2'b10:   edges_needed = 4'h5;
      default: edges_needed = 4'h9;
    endcase
  endfunction

  function automatic logic [5:0] guard_ticks(input logic [1:0] sel);
    case (sel)
      2'b00:   guard_ticks = 6'(GUARD_MIN_TICKS);
      2'b01:   guard_ticks = 6'h10;
      2'b10:   guard_ticks = 6'h20;
      default: guard_ticks = GUARD_MAX_TICKS;
    endcase
  endfunction

endpackage

// ===== hdl/ftl_drive_stage.sv
/*
 * one drive output: 256-step duty counter plus a spin-up hold.
 * assumes step is a one-cycle enable in the clk domain.
 */
`timescale 1ns/1ps
module ftl_drive_stage (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       step,
  input  wire logic [7:0] duty,
  input  wire logic       hold_high,
  // drive
  output      logic       drive_out
);

  logic [7:0] phase_reg;
  logic       out_reg;
  wire        duty_high = (phase_reg < duty);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 8'h00;
      out_reg   <= 1'b0;
    end else begin
      if (step) begin
        phase_reg <= phase_reg + 8'h01;
      end
      // full duty leaves one low step in 256
      out_reg <= hold_high | duty_high;
    end
  end

  assign drive_out = out_reg;

endmodule

// ===== hdl/ftl_tach_meter.sv
/*
 * one speed input measurement: guard, edge count and stall or slow coding.
 * assumes edge_seen is already synchronised and tick is the 90 kHz enable.
 */
`timescale 1ns/1ps
module ftl_tach_meter (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // timing and input
  input  wire logic                tick,
  input  wire logic                edge_seen,
  input  wire logic                gate,
  input  wire ftl_pkg::ftl_opt_t   opt,
  // result
  output      ftl_pkg::ftl_result_t result
);

  ftl_pkg::ftl_state_t state_reg, state_next;
  logic [5:0]  guard_reg, guard_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0]  edges_reg, edges_next;
  logic        done_reg, done_next;
  logic [15:0] value_reg, value_next;

  wire        gate_on  = opt.sync_mode ? gate : 1'b1;
  wire [3:0]  need     = ftl_pkg::edges_needed(opt.edge_sel);
  wire [5:0]  guard_n  = ftl_pkg::guard_ticks(opt.guard_sel);
  wire        cnt_full = (cnt_reg == 16'hFFFF);
  wire [15:0] slow_val = opt.slow_sel ? ftl_pkg::READ_SLOW : ftl_pkg::READ_STALL;
  wire        rest     = opt.sync_mode ? 1'b1 : 1'b0;

  always_comb begin
    state_next = state_reg;
    guard_next = guard_reg;
    cnt_next   = cnt_reg;
    edges_next = edges_reg;
    done_next  = 1'b0;
    value_next = value_reg;
    case (state_reg)
      ftl_pkg::ST_IDLE: begin
        guard_next = 6'h00;
        cnt_next   = 16'h0000;
        edges_next = 4'h0;
        if (gate_on) begin
          state_next = opt.sync_mode ? ftl_pkg::ST_GUARD : ftl_pkg::ST_ARM;
        end
      end
      ftl_pkg::ST_GUARD: begin
        // edges during the guard are ignored
        if (!gate_on) begin
          state_next = ftl_pkg::ST_IDLE;
        end else if (tick) begin
          guard_next = guard_reg + 6'h01;
          if (guard_reg + 6'h01 >= guard_n) begin
            state_next = ftl_pkg::ST_ARM;
          end
        end
      end
      ftl_pkg::ST_ARM: begin
        if (edge_seen && gate_on) begin
          state_next = ftl_pkg::ST_COUNT;
          cnt_next   = 16'h0000;
          edges_next = 4'h1;
        end else if (!gate_on || (tick && cnt_full)) begin
          done_next  = 1'b1;
          value_next = ftl_pkg::READ_STALL;
          state_next = rest ? ftl_pkg::ST_HOLD : ftl_pkg::ST_IDLE;
        end else if (tick) begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      ftl_pkg::ST_COUNT: begin
        if (edge_seen && gate_on && (edges_reg + 4'h1 == need)) begin
          // window must hold a full period for 3 edges, half for 2
          done_next  = 1'b1;
          value_next = cnt_reg;
          state_next = rest ? ftl_pkg::ST_HOLD : ftl_pkg::ST_IDLE;
        end else if (!gate_on || (tick && cnt_full)) begin
          done_next  = 1'b1;
          value_next = slow_val;
          state_next = rest ? ftl_pkg::ST_HOLD : ftl_pkg::ST_IDLE;
        end else begin
          if (edge_seen) begin
            edges_next = edges_reg + 4'h1;
          end
          if (tick) begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
      end
      ftl_pkg::ST_HOLD: begin
        // one measurement per drive-on interval
        if (!gate_on) begin
          state_next = ftl_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = ftl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ftl_pkg::ST_IDLE;
      guard_reg <= 6'h00;
      cnt_reg   <= 16'h0000;
      edges_reg <= 4'h0;
      done_reg  <= 1'b0;
      value_reg <= ftl_pkg::READ_STALL;
    end else begin
      state_reg <= state_next;
      guard_reg <= guard_next;
      cnt_reg   <= cnt_next;
      edges_reg <= edges_next;
      done_reg  <= done_next;
      value_reg <= value_next;
    end
  end

  assign result = {done_reg, value_reg};

endmodule

// ===== hdl/ftl_top.sv
/*
 * fan speed supervision: four speed inputs, three drive outputs, fault
 * coding of readings, fan event status, drive/speed association.
 * assumes the serial management engine outside presents one-cycle
 * register read and write strobes in the CLK domain; speed pins are
 * asynchronous and synchronised here.
 */
// Behaviour
// - speed logic assumes five tachometer edges per fan revolution.
// - after drive goes high, ignore edges for a guard time, least 88.88 us.
// - with three edges, drive must stay high one tachometer period past guard.
// - full duty holds drive high 255 of every 256 steps.
// - with two edges, longest period is twice drive-high minus guard time.
// - set fan fail flag when reading exceeds its programmed minimum limit.
// - no edge in a measurement forces the reading to all ones.
// - slow fan forces reading to FFFEh or FFFFh by slow-report bit.
// - reading stays all ones while stalled; next valid count latches later.
// - status bit sets only above limit and with its enable bit set.
// - limit of all ones blocks the status bit, even when stalled.
// - per-input enables reset on, group enable resets off and gates interrupt.
// - association register maps each speed input to one drive output.
// - spin-up cut releases drive hold once associated input runs normally.
// - synchronised mode gates measurement by associated drive on/off.
// - fan events for an input are suppressed while its drive is off.
// - reset link: drive 1 to input 1, 2 to 2, 3 to 3 and 4.
// - synchronised mode measures only while associated drive is high.
// - edges per measurement programmable as 2, 3, 5 or 9.
// - guard time programmable from 8 to 63 measurement clock periods.
// - low byte read first; high byte held latched for coherent pair.
`timescale 1ns/1ps
module ftl_top #(
  parameter int unsigned N_TACH  = 4,
  parameter int unsigned N_DRIVE = 3
) (
  // clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RST_B,
  // register strobes from the management engine
  input  wire logic [7:0]               REG_ADDR,
  input  wire logic [7:0]               REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  output      logic [7:0]               REG_RDATA,
  // speed pins
  input  wire logic [N_TACH-1:0]        TACH_IN,
  // automatic control requests
  input  wire logic [N_DRIVE-1:0][7:0]  DRIVE_DUTY,
  input  wire logic [N_DRIVE-1:0]       SPINUP_REQ,
  // drive pins and interrupt
  output      logic [N_DRIVE-1:0]       DRIVE_OUT,
  output      logic                     INT_B
);

  // ==========================================================================
  // registers
  logic [7:0]  config_reg;
  logic [7:0]  enable_reg;
  logic [7:0]  link_reg;
  logic [7:0]  status_reg, status_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        int_b_reg;
  logic [7:0]  opt_reg   [N_TACH];
  logic [15:0] limit_reg [N_TACH];
  logic [15:0] read_reg  [N_TACH];
  logic [7:0]  hi_shadow_reg [N_TACH];

  // ==========================================================================
  // measurement clock enable
  logic [10:0] tick_cnt_reg;
  logic        tick_reg;
  wire         tick_wrap = (tick_cnt_reg == 11'(ftl_pkg::TICK_CYCLES - 1));

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tick_cnt_reg <= 11'h000;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? 11'h000 : tick_cnt_reg + 11'h001;
      tick_reg     <= tick_wrap;
    end
  end

  // ==========================================================================
  // speed pin synchroniser and edge detect
  logic [N_TACH-1:0] tach_s1_reg;
  logic [N_TACH-1:0] tach_s2_reg;
  logic [N_TACH-1:0] tach_s3_reg;
  wire  [N_TACH-1:0] tach_edge = tach_s2_reg ^ tach_s3_reg;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tach_s1_reg <= '1;
      tach_s2_reg <= '1;
      tach_s3_reg <= '1;
    end else begin
      tach_s1_reg <= TACH_IN;
      tach_s2_reg <= tach_s1_reg;
      tach_s3_reg <= tach_s2_reg;
    end
  end

  // ==========================================================================
  // association and drive levels
  function automatic logic [1:0] link_of(input logic [7:0] link, input int idx);
    link_of = link[2*idx +: 2];
  endfunction

  logic [N_DRIVE-1:0] drive_lvl;
  logic [N_TACH-1:0]  tach_gate;
  logic [N_TACH-1:0]  tach_normal;
  logic [N_DRIVE-1:0] drive_normal;
  logic [N_DRIVE-1:0] hold_high;

  always_comb begin
    for (int t = 0; t < N_TACH; t++) begin
      tach_gate[t] = 1'b0;
      for (int d = 0; d < N_DRIVE; d++) begin
        if (link_of(link_reg, t) == 2'(d)) begin
          tach_gate[t] = drive_lvl[d];
        end
      end
    end
  end

  always_comb begin
    for (int t = 0; t < N_TACH; t++) begin
      tach_normal[t] = (read_reg[t] <= limit_reg[t])
                     && (read_reg[t] != ftl_pkg::READ_STALL)
                     && (read_reg[t] != ftl_pkg::READ_SLOW);
    end
    for (int d = 0; d < N_DRIVE; d++) begin
      drive_normal[d] = 1'b0;
      for (int t = 0; t < N_TACH; t++) begin
        if (link_of(link_reg, t) == 2'(d) && tach_normal[t]) begin
          drive_normal[d] = 1'b1;
        end
      end
    end
  end

  wire spin_cut = config_reg[ftl_pkg::CONFIG_SPINCUT];

  // spin-up hold ends early once the fan is seen turning
  assign hold_high = SPINUP_REQ & ~({N_DRIVE{spin_cut}} & drive_normal);

  genvar gd;
  generate
    for (gd = 0; gd < N_DRIVE; gd++) begin : g_drive
      ftl_drive_stage u_drive (
        .clk       (CLK),
        .rst_b     (RST_B),
        .step      (tick_reg),
        .duty      (DRIVE_DUTY[gd]),
        .hold_high (hold_high[gd]),
        .drive_out (drive_lvl[gd])
      );
    end
  endgenerate

  // ==========================================================================
  // measurement channels
  ftl_pkg::ftl_result_t result [N_TACH];

  genvar gt;
  generate
    for (gt = 0; gt < N_TACH; gt++) begin : g_tach
      ftl_tach_meter u_meter (
        .clk       (CLK),
        .rst_b     (RST_B),
        .tick      (tick_reg),
        .edge_seen (tach_edge[gt]),
        .gate      (tach_gate[gt]),
        .opt       (ftl_pkg::ftl_opt_t'(opt_reg[gt])),
        .result    (result[gt])
      );
    end
  endgenerate

  // ==========================================================================
  // address decode
  wire       hit_read   = (REG_ADDR >= ftl_pkg::ADDR_READ_BASE)
                       && (REG_ADDR <= ftl_pkg::ADDR_READ_LAST);
  wire       hit_limit  = (REG_ADDR >= ftl_pkg::ADDR_LIMIT_BASE)
                       && (REG_ADDR <= ftl_pkg::ADDR_LIMIT_LAST);
  wire       hit_opt    = (REG_ADDR >= ftl_pkg::ADDR_OPT_BASE)
                       && (REG_ADDR <= ftl_pkg::ADDR_OPT_LAST);
  wire [7:0] read_off   = REG_ADDR - ftl_pkg::ADDR_READ_BASE;
  wire [7:0] limit_off  = REG_ADDR - ftl_pkg::ADDR_LIMIT_BASE;
  wire [7:0] opt_off    = REG_ADDR - ftl_pkg::ADDR_OPT_BASE;
  wire [1:0] read_idx   = read_off[2:1];
  wire [1:0] limit_idx  = limit_off[2:1];
  wire [1:0] opt_idx    = opt_off[1:0];
  wire       status_rd  = REG_RD && (REG_ADDR == ftl_pkg::ADDR_STATUS);
  wire       group_en   = enable_reg[ftl_pkg::ENABLE_GROUP];

  // ==========================================================================
  // fan event conditions
  logic [N_TACH-1:0] fan_cond;

  always_comb begin
    for (int t = 0; t < N_TACH; t++) begin
      fan_cond[t] = (read_reg[t] > limit_reg[t])
                  && (limit_reg[t] != ftl_pkg::LIMIT_OFF)
                  && enable_reg[ftl_pkg::STAT_TACH_LSB + t]
                  && tach_gate[t];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_comb begin
    status_next = status_reg & ~(status_rd ? status_reg : 8'h00);
    status_next[ftl_pkg::STAT_TACH_LSB +: N_TACH] =
      status_next[ftl_pkg::STAT_TACH_LSB +: N_TACH] | fan_cond;
  end

  wire int_on = group_en
             && |(status_reg & enable_reg & 8'(((1 << N_TACH) - 1) << ftl_pkg::STAT_TACH_LSB));

  // ==========================================================================
  // read data
  always_comb begin
    rdata_next = 8'h00;
    if (hit_read) begin
      // high byte comes from the copy taken at the low-byte read
      rdata_next = read_off[0] ? hi_shadow_reg[read_idx] : read_reg[read_idx][7:0];
    end else if (hit_limit) begin
      rdata_next = limit_off[0] ? limit_reg[limit_idx][15:8] : limit_reg[limit_idx][7:0];
    end else if (hit_opt) begin
      rdata_next = opt_reg[opt_idx];
    end else begin
      case (REG_ADDR)
        ftl_pkg::ADDR_STATUS: rdata_next = status_reg;
        ftl_pkg::ADDR_CONFIG: rdata_next = config_reg;
        ftl_pkg::ADDR_ENABLE: rdata_next = enable_reg;
        ftl_pkg::ADDR_LINK:   rdata_next = link_reg;
        default:              rdata_next = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      config_reg <= ftl_pkg::RST_CONFIG;
      enable_reg <= ftl_pkg::RST_ENABLE;
      link_reg   <= ftl_pkg::RST_LINK;
    end else if (REG_WR) begin
      if (REG_ADDR == ftl_pkg::ADDR_CONFIG) begin
        config_reg <= REG_WDATA;
      end
      if (REG_ADDR == ftl_pkg::ADDR_ENABLE) begin
        enable_reg <= REG_WDATA;
      end
      if (REG_ADDR == ftl_pkg::ADDR_LINK) begin
        link_reg <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int t = 0; t < N_TACH; t++) begin
        opt_reg[t]   <= ftl_pkg::RST_OPT;
        limit_reg[t] <= ftl_pkg::RST_LIMIT;
      end
    end else if (REG_WR) begin
      if (hit_opt) begin
        opt_reg[opt_idx] <= REG_WDATA;
      end
      if (hit_limit && limit_off[0]) begin
        limit_reg[limit_idx][15:8] <= REG_WDATA;
      end
      if (hit_limit && !limit_off[0]) begin
        limit_reg[limit_idx][7:0] <= REG_WDATA;
      end
    end
  end

  // ==========================================================================
  // readings and byte pairing
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int t = 0; t < N_TACH; t++) begin
        read_reg[t]      <= ftl_pkg::READ_STALL;
        hi_shadow_reg[t] <= 8'h00;
      end
    end else begin
      for (int t = 0; t < N_TACH; t++) begin
        if (result[t].done) begin
          read_reg[t] <= result[t].value;
        end
      end
      if (REG_RD && hit_read && !read_off[0]) begin
        hi_shadow_reg[read_idx] <= read_reg[read_idx][15:8];
      end
    end
  end

  // ==========================================================================
  // status, interrupt and read port
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      status_reg <= 8'h00;
      int_b_reg  <= 1'b1;
      rdata_reg  <= 8'h00;
    end else begin
      status_reg <= status_next;
      int_b_reg  <= ~int_on;
      if (REG_RD) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign REG_RDATA = rdata_reg;
  assign DRIVE_OUT = drive_lvl;
  assign INT_B     = int_b_reg;

endmodule

// ===== tb/ftl_top_checker.sv
/* port-level assertions for ftl_top.
   assumes the bind below attaches it to every ftl_top. */
`timescale 1ns/1ps
module ftl_top_checker #(
  parameter int unsigned N_TACH  = 4,
  parameter int unsigned N_DRIVE = 3
) (
  // watched ports
  input wire logic                    CLK,
  input wire logic                    RST_B,
  input wire logic [7:0]              REG_ADDR,
  input wire logic [7:0]              REG_WDATA,
  input wire logic                    REG_WR,
  input wire logic                    REG_RD,
  input wire logic [7:0]              REG_RDATA,
  input wire logic [N_TACH-1:0]       TACH_IN,
  input wire logic [N_DRIVE-1:0][7:0] DRIVE_DUTY,
  input wire logic [N_DRIVE-1:0]      SPINUP_REQ,
  input wire logic [N_DRIVE-1:0]      DRIVE_OUT,
  input wire logic                    INT_B
);
  // ==========================================
  // shadow of the enable, link and config registers, and a full-duty low-run counter
  wire wr_en  = REG_WR && REG_ADDR == ftl_pkg::ADDR_ENABLE;
  wire wr_lnk = REG_WR && REG_ADDR == ftl_pkg::ADDR_LINK;
  wire wr_cfg = REG_WR && REG_ADDR == ftl_pkg::ADDR_CONFIG;
  wire lo_run = DRIVE_DUTY[1] == 8'hFF && !SPINUP_REQ[1] && !DRIVE_OUT[1];
  logic [7:0]  en_reg;
  logic [7:0]  lnk_reg;
  logic [7:0]  cfg_reg;
  logic [11:0] low_reg;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      en_reg  <= ftl_pkg::RST_ENABLE;
      lnk_reg <= ftl_pkg::RST_LINK;
      cfg_reg <= ftl_pkg::RST_CONFIG;
      low_reg <= 12'h000;
    end else begin
      en_reg  <= wr_en ? REG_WDATA : en_reg;
      lnk_reg <= wr_lnk ? REG_WDATA : lnk_reg;
      cfg_reg <= wr_cfg ? REG_WDATA : cfg_reg;
      low_reg <= lo_run ? low_reg + 12'h001 : 12'h000;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  enable_rb_a: assert property (REG_RD && REG_ADDR == 8'h80 |=> REG_RDATA == $past(en_reg))
    else $error("enable readback differs");
  link_rb_a: assert property (REG_RD && REG_ADDR == 8'h81 |=> REG_RDATA == $past(lnk_reg))
    else $error("link readback differs");
  config_rb_a: assert property (REG_RD && REG_ADDR == 8'h7F |=> REG_RDATA == $past(cfg_reg))
    else $error("config readback differs");
  int_gate_a: assert property ((!en_reg[0])[*2] |-> INT_B)
    else $error("interrupt low with group off");
  int_low_a: assert property ($fell(INT_B) |-> $past(en_reg[0]))
    else $error("interrupt fell without group enable");
  duty_zero_a: assert property (DRIVE_DUTY[0] == 8'h00 && !SPINUP_REQ[0] |=> !DRIVE_OUT[0])
    else $error("drive high at zero duty");
  full_duty_a: assert property (low_reg <= 12'(ftl_pkg::TICK_CYCLES + 1))
    else $error("full duty low for over one step");
  spin_hold_a: assert property (SPINUP_REQ[0] && !cfg_reg[4] |=> DRIVE_OUT[0])
    else $error("spin-up hold not driven");
endmodule
bind ftl_top ftl_top_checker #(.N_TACH(N_TACH), .N_DRIVE(N_DRIVE)) chk (
  .CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .TACH_IN(TACH_IN), .DRIVE_DUTY(DRIVE_DUTY),
  .SPINUP_REQ(SPINUP_REQ), .DRIVE_OUT(DRIVE_OUT), .INT_B(INT_B));

// ===== tb/ftl_fan_model.sv
/* behavioural fan with a tach output.
   assumes drive comes from the device pin and half is in system clocks. */
`timescale 1ns/1ps
module ftl_fan_model (
  // clock
  input  wire logic clk,
  // control
  input  wire logic drive,
  input  wire logic spin,
  input  var  int   half,
  // tach pin
  output      logic tach
);
  int cnt = 0;
  initial tach = 1'b1;
  // each half period is one of the five edges of a turn
  always @(posedge clk) begin
    if (!spin)
      tach <= 1'b1;
    else if (!drive)
      tach <= ~tach; // unpowered sensor: pin is not trustworthy
    else if (cnt >= half - 1) begin
      cnt  <= 0;
      tach <= ~tach;
    end else
      cnt <= cnt + 1;
  end
endmodule

// ===== tb/ftl_top_test.sv
/* self-checking bench for ftl_top: registers, drive-gated measurement, status.
   assumes the checker and the fan model are compiled alongside. */
`timescale 1ns/1ps
module ftl_top_test;
  logic            clk = 1'b0;
  logic            rst_b = 1'b0;
  logic [7:0]      addr = 8'h00;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            spin = 1'b0;
  logic            rd_seen = 1'b0;
  logic [2:0][7:0] duty = {8'h00, 8'hFF, 8'h00};
  logic [2:0]      spinup = 3'b000;
  logic [3:0]      tach;
  logic [7:0]      rdata;
  logic [2:0]      drv;
  logic            int_b;
  logic [15:0]     lfsr = 16'hECED;
  logic [23:0]     exp_q[$];
  logic [23:0]     note;
  int              half = 2000;
  int              error_cnt = 0;
  int              tests_run = 0;
  int              cyc = 0;
  logic [15:0]     rst_tab[10] = '{16'h4200, 16'h7F00, 16'h803C, 16'h81A4, 16'h9000,
                                   16'h54FF, 16'h5BFF, 16'h28FF, 16'h29FF, 16'h2000};

  initial begin
    forever #5 clk = ~clk;
  end
  ftl_top uut (.CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .TACH_IN(tach), .DRIVE_DUTY(duty), .SPINUP_REQ(spinup),
    .DRIVE_OUT(drv), .INT_B(int_b));
  for (genvar i = 0; i < 4; i++) begin : g_fan
    ftl_fan_model fan (.clk(clk), .drive(drv[i == 3 ? 2 : i]), .spin(i == 0 ? spin : 1'b0),
      .half(half), .tach(tach[i]));
  end

  // ==========================================
  // tasks
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    exp_q.push_back({a, m, e});
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    rd_reg(a, e[7:0], m[7:0]);
    rd_reg(a + 8'h01, e[15:8], m[15:8]);
  endtask
  // leaves the drive high so status can be read inside the window
  task automatic measure(input logic [7:0] opt, input logic s, input int h);
    wr_reg(8'h90, opt);
    spin = s;
    half = h;
    @(negedge clk);
    spinup[0] = 1'b1;
    repeat (16000) @(negedge clk);
  endtask
  task automatic drop();
    spinup[0] = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================
  // result watcher and hang guard
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      note = exp_q.pop_front();
      check($sformatf("reg %h", note[23:16]), rdata & note[15:8], note[7:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    wr_reg(8'h42, 8'hFF);
    foreach (rst_tab[i]) rd_reg(rst_tab[i][15:8], rst_tab[i][7:0]);
    // events masked while limits are random
    wr_reg(8'h80, 8'h00);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      wr_reg(8'h81, lfsr[7:0]);
      rd_reg(8'h81, lfsr[7:0]);
      wr_reg(8'h56, lfsr[15:8]);
      rd_reg(8'h56, lfsr[15:8]);
    end
    wr_reg(8'h81, 8'hA4);
    wr_reg(8'h56, 8'hFF);
    wr_reg(8'h80, 8'h3C);
    $display("register test done");
    wr_reg(8'h54, 8'h00);
    wr_reg(8'h55, 8'h00);
    measure(8'h20, 1'b1, 2000);
    rd16(8'h28, 16'h0000, 16'hFFFC);
    rd_reg(8'h42, 8'h04);
    check("int pin", {7'h00, int_b}, 8'h01);
    wr_reg(8'h80, 8'h3D);
    repeat (3) @(negedge clk);
    check("int pin", {7'h00, int_b}, 8'h00);
    drop();
    rd_reg(8'h42, 8'h04);
    rd_reg(8'h42, 8'h00);
    repeat (3) @(negedge clk);
    check("int pin", {7'h00, int_b}, 8'h01);
    $display("valid speed test done");
    wr_reg(8'h54, 8'hFF);
    wr_reg(8'h55, 8'hFF);
    measure(8'h00, 1'b1, 2000);
    rd16(8'h28, 16'h0000, 16'hFFFC);
    wr_reg(8'h7F, 8'h10);
    repeat (2) @(negedge clk);
    check("drive 1", {7'h00, drv[0]}, 8'h00);
    drop();
    wr_reg(8'h7F, 8'h00);
    measure(8'h20, 1'b0, 2000);
    drop();
    rd16(8'h28, 16'hFFFF, 16'hFFFF);
    measure(8'h27, 1'b1, 2500);
    rd_reg(8'h42, 8'h00);
    drop();
    rd16(8'h28, 16'hFFFE, 16'hFFFF);
    measure(8'h26, 1'b1, 2500);
    drop();
    rd16(8'h28, 16'hFFFF, 16'hFFFF);
    repeat (4) @(negedge clk);
    $display("stall and slow test done");
    wrap_up();
  end
endmodule
